// ===== dv/smd_mcu_model.sv
// Access master in place of the external controller
module smd_mcu_model (
  // Clock
  input  wire logic        ref_clk,
  // Access request
  output      logic        spiValid,
  output      logic        spiWrite,
  output      logic [2:0]  spiAreaSel,
  output      logic [9:0]  spiAddr,
  output      logic [15:0] spiWdata,
  // Answer
  input  wire logic [15:0] rdData,
  input  wire logic        rdValid,
  input  wire logic        wrRefused,
  input  wire logic [2:0]  first_channel_select,
  input  wire logic [2:0]  second_channel_select
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle at time zero
  initial begin
    spiValid = 1'b0;
    spiWrite = 1'b0;
    spiAreaSel = 3'h0;
    spiAddr = 10'h000;
    spiWdata = 16'h0000;
  end
  // One access: taken at edge 0, selects stand after it, answer stands after edge 1
  task automatic xfer(input logic w, input logic [2:0] s, input logic [9:0] a,
    input logic [15:0] d, output logic [6:0] sel, output logic [16:0] rd);
    spiValid = 1'b1;
    spiWrite = w;
    spiAreaSel = s;
    spiAddr = a;
    spiWdata = d;
    @(posedge ref_clk);
    #1;
    sel = {wrRefused, second_channel_select, first_channel_select};
    // Released lines are scrambled so nothing leans on stale values
    spiValid = 1'b0;
    spiWrite = ~w;
    spiAreaSel = ~s;
    spiAddr = ~a;
    spiWdata = ~d;
    @(posedge ref_clk);
    #1;
    rd = {rdValid, rdData};
  endtask
endmodule

// ===== dv/smd_memory_map_checker.sv
module smd_memory_map_checker
  import smd_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // Access request
  input  wire logic        spiValid,
  input  wire logic        spiWrite,
  input  wire logic [2:0]  spiAreaSel,
  input  wire logic [9:0]  spiAddr,
  input  wire logic        lockActive,
  // Answers
  input  wire logic        rdValid,
  input  wire logic        wrRefused,
  input  wire logic [2:0]  first_channel_select,
  input  wire logic [2:0]  second_channel_select,
  input  wire logic [4:0]  cfgBankSel,
  input  wire logic [1:0]  instrValid,
  input  wire logic        bistBusy,
  input  wire logic        bistDone
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // An access is only taken while self test is idle
  logic take;
  logic dsel;
  assign take = spiValid && !bistBusy;
  assign dsel = take && spiAreaSel == SEL_DATA;

  a_code1_area: assert property (take && spiAreaSel == SEL_CODE1 && spiAddr <= CODE_LAST
    |=> first_channel_select == 3'h2 && second_channel_select == 3'h0) else $error("code1 sel");
  a_code2_area: assert property (take && spiAreaSel == SEL_CODE2 && spiAddr <= CODE_LAST
    |=> second_channel_select == 3'h2 && first_channel_select == 3'h0) else $error("code2 sel");
  a_data1_shared: assert property (dsel && spiAddr < 10'h030
    |=> first_channel_select == 3'h1 && !wrRefused) else $error("data1 shared");
  a_priv_lock: assert property (dsel && spiWrite && lockActive && spiAddr[9:4] == 6'h03
    |=> wrRefused && first_channel_select == 3'h1) else $error("private lock");
  a_data2_area: assert property (dsel && spiAddr[9:6] == 4'h1 |=>
    second_channel_select == 3'h1
    && wrRefused == $past(spiWrite && lockActive && spiAddr[5:4] == 2'h3)) else $error("data2");
  a_unlocked_write: assert property (take && spiWrite && !lockActive |=> !wrRefused)
    else $error("refused unlocked");
  a_answer_time: assert property (take |-> ##2 rdValid) else $error("no answer");
  a_one_area: assert property ($onehot0({first_channel_select, second_channel_select}))
    else $error("two areas");
  a_busy_blocks: assert property (spiValid && bistBusy |=>
    first_channel_select == 3'h0 && second_channel_select == 3'h0 && cfgBankSel == 5'h00)
    else $error("access in self test");
  a_cfg_bank: assert property (dsel && spiAddr >= CFG_FIRST && spiAddr <= CFG_LAST
    |=> cfgBankSel == 5'h01 << $past(spiAddr[7:5])) else $error("bank select");
  a_bist_length: assert property ($rose(bistBusy) |-> ##[100:250] bistDone)
    else $error("self test length");

  // Main scenarios reached
  c_locked: cover property (take && spiWrite && lockActive ##1 wrRefused);
  c_bist: cover property ($rose(bistDone));
  c_fetch: cover property (instrValid[0] && instrValid[1]);
endmodule

bind smd_memory_map smd_memory_map_checker #(.TICK_DIV(TICK_DIV)) chk_i (
  .ref_clk, .rstn, .spiValid, .spiWrite, .spiAreaSel, .spiAddr, .lockActive, .rdValid,
  .wrRefused, .first_channel_select, .second_channel_select, .cfgBankSel, .instrValid,
  .bistBusy, .bistDone);

// ===== dv/smd_memory_map_tb.sv
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin failures++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end

module smd_memory_map_tb import smd_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0, rstn, lockActive, bistStart, spiValid, spiWrite, rdValid, wrRefused;
  logic bistBusy, bistDone, bistFail;
  logic [3:0] coreRun;
  logic [2:0] spiAreaSel, s1, s2;
  logic [9:0] spiAddr;
  logic [15:0] spiWdata, rdData;
  logic [4:0] cfgBankSel;
  logic [31:0] instrWord;
  logic [1:0] instrCore, instrValid;
  logic [6:0] sel;
  logic [16:0] rd;
  logic [15:0] mem [int];
  logic [12:0] corner [23] = '{13'h0400, 13'h07FE, 13'h07FF, 13'h0800, 13'h0BFE, 13'h102F,
    13'h1030, 13'h103F, 13'h1040, 13'h106F, 13'h1070, 13'h107F, 13'h1080, 13'h1100, 13'h1120,
    13'h1140, 13'h1160, 13'h1180, 13'h119F, 13'h11A0, 13'h0C00, 13'h0000, 13'h1C00};
  int failures = 0, checks_done = 0, n0, n1;

  always #5 ref_clk = ~ref_clk;

  smd_memory_map #(.TICK_DIV(4)) smd_memory_map_i (.ref_clk, .rstn, .spiValid, .spiWrite,
    .spiAreaSel, .spiAddr, .spiWdata, .lockActive, .rdData, .rdValid, .wrRefused,
    .first_channel_select(s1), .second_channel_select(s2), .cfgBankSel, .coreRun, .instrWord,
    .instrCore, .instrValid, .bistStart, .bistBusy, .bistDone, .bistFail);
  smd_mcu_model smd_mcu_model_i (.ref_clk, .spiValid, .spiWrite, .spiAreaSel, .spiAddr,
    .spiWdata, .rdData, .rdValid, .wrRefused, .first_channel_select(s1),
    .second_channel_select(s2));

  // {refused, channel 2 selects, channel 1 selects} expected for one access
  function automatic logic [6:0] exp_sel(input logic [2:0] s, input logic [9:0] a,
    input logic w);
    logic cd, dt, lk;
    cd = a <= CODE_LAST;
    dt = s == SEL_DATA && a < 10'h080;
    lk = ((s == SEL_CODE1 || s == SEL_CODE2) && cd) || (dt && a[5:4] == 2'h3);
    return {lk & w & lockActive,
      s == SEL_DATA && a[9:5] == 5'h09, s == SEL_CODE2 && cd, dt && a[6],
      s == SEL_DATA && a[9:5] == 5'h08, s == SEL_CODE1 && cd, dt && !a[6]};
  endfunction

  // Access with its checks; the shadow holds only words the memories must keep
  task automatic acc(input logic w, input logic [2:0] s, input logic [9:0] a,
    input logic [15:0] d);
    logic [6:0] es;
    logic cf;
    int k;
    k = {s, a};
    cf = s == SEL_DATA && a >= CFG_FIRST && a <= CFG_LAST;
    es = exp_sel(s, a, w);
    smd_mcu_model_i.xfer(w, s, a, d, sel, rd);
    `CHK("selects", es, sel)
    `CHK("answer strobe", 1'b1, rd[16])
    if (!w && mem.exists(k)) `CHK("read data", mem[k], rd[15:0])
    if (!w && es[5:0] == 6'h00 && !cf) `CHK("unmapped read", 16'h0000, rd[15:0])
    if (w && !es[6] && (|{es[4:3], es[1:0]} || cf)) mem[k] = d;
  endtask

  task automatic give_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    rstn = 1'b0;
    lockActive = 1'b0;
    bistStart = 1'b0;
    coreRun = 4'h0;
    void'($urandom(57486));
    repeat (4) @(posedge ref_clk);
    #1 rstn = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    // Area boundaries, unlocked then locked
    for (int l = 0; l < 2; l++) begin
      lockActive = l[0];
      foreach (corner[i]) begin
        acc(1'b1, corner[i][12:10], corner[i][9:0], 16'h5A00 + 16'(i) + 16'(l * 32));
        acc(1'b0, corner[i][12:10], corner[i][9:0], 16'h0000);
      end
    end
    $display("test corners done");
    // Random traffic over all areas and lock states
    repeat (300) begin
      logic [2:0] s;
      s = 3'h1 << $urandom_range(2);
      lockActive = 1'($urandom);
      acc(1'($urandom), s, 10'($urandom_range(s == SEL_DATA ? 10'h1A0 : 10'h3FF)),
        16'($urandom));
    end
    lockActive = 1'b0;
    $display("test random done");
    // Self test refuses accesses while it runs
    bistStart = 1'b1;
    @(posedge ref_clk);
    #1 bistStart = 1'b0;
    `CHK("busy", 1'b1, bistBusy)
    smd_mcu_model_i.xfer(1'b0, SEL_DATA, 10'h010, 16'h0000, sel, rd);
    `CHK("busy selects", 6'h00, sel[5:0])
    `CHK("busy read", 16'h0000, rd[15:0])
    for (n0 = 0; n0 < 300 && bistDone !== 1'b1; n0++) begin
      @(posedge ref_clk);
      #1;
    end
    `CHK("self test done", 2'h2, {bistDone, bistFail})
    mem.delete();
    $display("test self test done");
    // Microcores fetch from code address 0 first; busy drops one edge after done
    repeat (2) @(posedge ref_clk);
    #1;
    acc(1'b1, SEL_CODE1, 10'h000, 16'hC0DE);
    acc(1'b1, SEL_CODE2, 10'h000, 16'h0E2A);
    coreRun = 4'h5;
    for (n0 = 0; n0 < 50 && instrValid[0] !== 1'b1; n0++) begin
      @(posedge ref_clk);
      #1;
    end
    if (n0 == 50)
      failures++;
    `CHK("first fetch", 32'h0E2AC0DE, instrWord)
    `CHK("first core", 2'h0, instrCore)
    acc(1'b0, SEL_CODE1, 10'h000, 16'h0000);
    n0 = 0;
    n1 = 0;
    repeat (40) begin
      @(posedge ref_clk);
      #1;
      n0 += int'(instrValid[0] === 1'b1);
      n1 += int'(instrValid[1] === 1'b1);
    end
    `CHK("fetch rate", 2'h3, {n0 >= 9 && n0 <= 11, n1 >= 9 && n1 <= 11})
    // Both cores of each channel running: fetches alternate between them
    coreRun = 4'hF;
    n0 = 0;
    n1 = 0;
    repeat (40) begin
      @(posedge ref_clk);
      #1;
      n0 += int'(instrValid[0] === 1'b1 && instrCore[0] === 1'b1);
      n1 += int'(instrValid[1] === 1'b1 && instrCore[1] === 1'b1);
    end
    `CHK("turn share", 2'h3, {n0 >= 4 && n0 <= 6, n1 >= 4 && n1 <= 6})
    $display("test microcores done");
    give_verdict();
  end
endmodule

// ===== logic/smd_memory_map.sv
// Overview of operation
// (R1) Every setup register is reachable from the SPI access port, grouped in banks.
// (R2) Separate banks: channel 1, channel 2, diagnosis, IO/thresholds, main configuration.
// (R3) Selection 001 reaches channel 1 code memory, addresses 0 to 0x3FE, lockable.
// (R4) Selection 010 reaches channel 2 code memory, addresses 0 to 0x3FE, lockable.
// (R5) Selection 100, addresses 0 to 0x02F: channel 1 shared data, never locked.
// (R6) Selection 100, addresses 0x030 to 0x03F: channel 1 private data, lockable.
// (R7) Top holds reset generation, clock management and self-test sub-functions.
// (R8) Each channel runs two microcores fetching code with dual sequencing.
// (R9) Selection 100: 0x040-0x06F shared, 0x070-0x07F private data of channel 2.
// (R10) While locked, writes to lockable areas are dropped; others proceed.
// (R11) Chip selects follow the decoded area; at most one is active.
module smd_memory_map
  import smd_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // SPI access request
  input  wire logic        spiValid,
  input  wire logic        spiWrite,
  input  wire logic [2:0]  spiAreaSel,
  input  wire logic [9:0]  spiAddr,
  input  wire logic [15:0] spiWdata,
  input  wire logic        lockActive,
  // SPI answer
  output      logic [15:0] rdData,
  output      logic        rdValid,
  output      logic        wrRefused,
  // Chip selects
  output      logic [2:0]  first_channel_select,
  output      logic [2:0]  second_channel_select,
  output      logic [4:0]  cfgBankSel,
  // Microcores
  input  wire logic [3:0]  coreRun,
  output      logic [31:0] instrWord,
  output      logic [1:0]  instrCore,
  output      logic [1:0]  instrValid,
  // Self test
  input  wire logic        bistStart,
  output      logic        bistBusy,
  output      logic        bistDone,
  output      logic        bistFail
);
  initial begin
    if (TICK_DIV < 1) $error("smd_memory_map: TICK_DIV must be at least 1");
  end
  // Area decode shared by the request and the answer paths
  function automatic smd_area_t decodeArea(input logic [2:0] sel, input logic [9:0] a);
    smd_area_t r = AR_NONE;
    if (sel == SEL_CODE1 && a <= CODE_LAST) begin
      r = AR_CODE1; // R3
    end else if (sel == SEL_CODE2 && a <= CODE_LAST) begin
      r = AR_CODE2; // R4
    end else if (sel == SEL_DATA && a <= DATA1_LAST) begin
      r = AR_DATA1; // R5
    end else if (sel == SEL_DATA && a <= DATA2_LAST) begin
      r = AR_DATA2; // R9
    end else if (sel == SEL_DATA && a >= CFG_FIRST && a <= CFG_LAST) begin
      r = AR_CFG; // R1
    end
    return r;
  endfunction
  // Code areas and the top quarter of each data area are lockable
  function automatic logic isLockable(input smd_area_t ar, input logic [9:0] a);
    return (ar == AR_CODE1) || (ar == AR_CODE2) ||
           (((ar == AR_DATA1) || (ar == AR_DATA2)) && (a[5:0] >= PRIV_FIRST)); // R6 R9
  endfunction
  // Reset generation: assert at once, release two edges after rstn rises
  logic rstMeta_r;
  logic rstSync_r;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1; // R7
      rstSync_r <= rstMeta_r;
    end
  end
  // Clock management: microsecond tick that paces the microcore fetch
  logic [$clog2(TICK_DIV+1)-1:0] tickCnt_r;
  logic                          tick_r;
  always_ff @(posedge ref_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      tickCnt_r <= '0;
      tick_r    <= 1'b0;
    end else begin
      tick_r    <= (32'(tickCnt_r) == TICK_DIV - 1); // R7
      tickCnt_r <= (32'(tickCnt_r) == TICK_DIV - 1) ? '0 : tickCnt_r + 1'b1;
    end
  end
  // Request decode; SPI is held off while the self test owns the memories
  smd_area_t   area;
  logic        spiTake;
  logic        wrAllowed;
  assign area      = decodeArea(spiAreaSel, spiAddr);
  assign spiTake   = spiValid && !bistBusy;
  assign wrAllowed = spiTake && spiWrite && !(lockActive && isLockable(area, spiAddr)); // R10
  // Self test over both data memories: write a pattern, then read it back
  smd_bist_t   bistSt_r;
  logic [5:0]  bistIdx_r;
  logic [5:0]  cmpIdx_r;
  logic        cmpValid_r;
  function automatic logic [15:0] bistPattern(input logic [5:0] i);
    return {i, ~i, 4'hA};
  endfunction
  always_ff @(posedge ref_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      bistSt_r  <= BS_IDLE;
      bistIdx_r <= 6'h00;
    end else begin
      case (bistSt_r) // R7
        BS_IDLE: begin
          if (bistStart) begin
            bistSt_r  <= BS_WRITE;
            bistIdx_r <= 6'h00;
          end
        end
        BS_WRITE, BS_READ: begin
          bistIdx_r <= bistIdx_r + 6'h01;
          if (bistIdx_r == 6'h3F) begin
            bistSt_r <= (bistSt_r == BS_WRITE) ? BS_READ : BS_DONE;
          end
        end
        BS_DONE: begin
          if (!cmpValid_r) begin
            bistSt_r <= BS_IDLE;
          end
        end
        default: bistSt_r <= BS_IDLE;
      endcase
    end
  end
  // Data memory ports, shared between SPI and self test
  logic [15:0] dataRd [2];
  logic [1:0]  dataWe;
  logic [5:0]  dataAddr;
  logic [15:0] dataWd;
  assign dataAddr  = bistBusy ? bistIdx_r : spiAddr[5:0];
  assign dataWd    = bistBusy ? bistPattern(bistIdx_r) : spiWdata;
  assign dataWe[0] = (bistSt_r == BS_WRITE) || (wrAllowed && area == AR_DATA1); // R5 R6
  assign dataWe[1] = (bistSt_r == BS_WRITE) || (wrAllowed && area == AR_DATA2); // R9
  // Compare read-back one cycle after each self-test read
  always_ff @(posedge ref_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      cmpValid_r <= 1'b0;
      cmpIdx_r   <= 6'h00;
      bistBusy   <= 1'b0;
      bistDone   <= 1'b0;
      bistFail   <= 1'b0;
    end else begin
      cmpValid_r <= (bistSt_r == BS_READ);
      cmpIdx_r   <= bistIdx_r;
      bistBusy   <= (bistSt_r != BS_IDLE) || (bistSt_r == BS_IDLE && bistStart);
      if (bistSt_r == BS_IDLE && bistStart) begin
        bistDone <= 1'b0;
        bistFail <= 1'b0;
      end else if (bistSt_r == BS_DONE && !cmpValid_r) begin
        bistDone <= 1'b1;
      end
      if (cmpValid_r && (dataRd[0] != bistPattern(cmpIdx_r) ||
                         dataRd[1] != bistPattern(cmpIdx_r))) begin
        bistFail <= 1'b1;
      end
    end
  end
  generate
    for (genvar d = 0; d < 2; d++) begin : g_data
      smd_ram #(.DW(16), .DEPTH(DATA_DEPTH), .AW(6)) u_data (
        .clk   (ref_clk),
        .we    (dataWe[d]),
        .addr  (dataAddr),
        .wdata (dataWd),
        .rdata (dataRd[d])
      );
    end
  endgenerate
  // Configuration banks: channel 1, channel 2, diagnosis, IO, main
  logic [15:0] cfgRd;
  logic [7:0]  cfgIdx;
  assign cfgIdx = 8'(spiAddr - CFG_FIRST);
  smd_ram #(.DW(16), .DEPTH(CFG_DEPTH), .AW(8)) u_cfg (
    .clk   (ref_clk),
    .we    (wrAllowed && area == AR_CFG), // R1 R2
    .addr  (cfgIdx),
    .wdata (spiWdata),
    .rdata (cfgRd)
  );
  // Microcores: two per channel, alternating fetch slots on each tick
  logic [9:0]  pc_r      [2][2];
  logic        turn_r    [2];
  logic        fetchCore [2];
  logic        fetch     [2];
  logic        fetched_r [2];
  logic        fetchId_r [2];
  logic [15:0] codeRd    [2];
  logic        codeSpi   [2];
  generate
    for (genvar c = 0; c < 2; c++) begin : g_chan
      // SPI access wins the code port; the cores retry on the next tick
      assign codeSpi[c]   = spiTake && (area == (c == 0 ? AR_CODE1 : AR_CODE2)); // R3 R4
      assign fetchCore[c] = coreRun[2*c + 32'(turn_r[c])] ? turn_r[c] : !turn_r[c];
      assign fetch[c]     = tick_r && !codeSpi[c] && |coreRun[2*c +: 2]; // R8
      smd_ram #(.DW(16), .DEPTH(CODE_DEPTH), .AW(10)) u_code (
        .clk   (ref_clk),
        .we    (codeSpi[c] && wrAllowed),
        .addr  (codeSpi[c] ? spiAddr : pc_r[c][fetchCore[c]]),
        .wdata (spiWdata),
        .rdata (codeRd[c])
      );
      // Dual sequencing: after each fetch the turn passes to the other core
      always_ff @(posedge ref_clk or negedge rstSync_r) begin
        if (!rstSync_r) begin
          pc_r[c][0]   <= PC_RST;
          pc_r[c][1]   <= PC_RST;
          turn_r[c]    <= 1'b0;
          fetched_r[c] <= 1'b0;
          fetchId_r[c] <= 1'b0;
        end else begin
          fetched_r[c] <= fetch[c];
          fetchId_r[c] <= fetchCore[c];
          if (fetch[c]) begin
            turn_r[c] <= !fetchCore[c]; // R8
            pc_r[c][fetchCore[c]] <= (pc_r[c][fetchCore[c]] == CODE_LAST) ?
                                     PC_RST : pc_r[c][fetchCore[c]] + 10'h001;
          end
          for (int k = 0; k < 2; k++) begin
            if (!coreRun[2*c + k]) begin
              pc_r[c][k] <= PC_RST; // Stopped core restarts at zero
            end
          end
        end
      end
      // Registered instruction outputs
      always_ff @(posedge ref_clk or negedge rstSync_r) begin
        if (!rstSync_r) begin
          instrWord[16*c +: 16] <= DATA_RST;
          instrCore[c]          <= 1'b0;
          instrValid[c]         <= 1'b0;
        end else begin
          instrValid[c] <= fetched_r[c];
          if (fetched_r[c]) begin
            instrWord[16*c +: 16] <= codeRd[c];
            instrCore[c]          <= fetchId_r[c];
          end
        end
      end
    end
  endgenerate
  // Access pipeline: chip selects in cycle 1, answer in cycle 2
  smd_area_t  area_r;
  logic       acc_r;
  logic [2:0] bank_r;
  always_ff @(posedge ref_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      area_r                <= AR_NONE;
      acc_r                 <= 1'b0;
      bank_r                <= 3'h0;
      first_channel_select  <= 3'h0;
      second_channel_select <= 3'h0;
      cfgBankSel            <= 5'h00;
      wrRefused             <= 1'b0;
    end else begin
      acc_r  <= spiValid;
      area_r <= spiTake ? area : AR_NONE;
      bank_r <= 3'(cfgIdx >> CFG_BANK_LSB);
      // At most one line by construction: a decoded area drives one line, none for the diagnosis, IO and main banks
      first_channel_select  <= {spiTake && area == AR_CFG && cfgIdx < 8'h20,
                                spiTake && area == AR_CODE1,
                                spiTake && area == AR_DATA1}; // R11
      second_channel_select <= {spiTake && area == AR_CFG && cfgIdx >= 8'h20 && cfgIdx < 8'h40,
                                spiTake && area == AR_CODE2,
                                spiTake && area == AR_DATA2}; // R11
      cfgBankSel <= (spiTake && area == AR_CFG) ?
                    5'(5'h01 << (cfgIdx >> CFG_BANK_LSB)) : 5'h00; // R2
      wrRefused  <= spiValid && spiWrite && !wrAllowed; // R10
    end
  end
  // Read answer; unmapped areas and accesses held off by the self test read zero
  always_ff @(posedge ref_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      rdData  <= DATA_RST;
      rdValid <= 1'b0;
    end else begin
      rdValid <= acc_r;
      case (area_r)
        AR_CODE1: rdData <= codeRd[0];
        AR_CODE2: rdData <= codeRd[1];
        AR_DATA1: rdData <= dataRd[0];
        AR_DATA2: rdData <= dataRd[1];
        AR_CFG:   rdData <= (32'(bank_r) < CFG_BANKS) ? cfgRd : DATA_RST;
        default:  rdData <= DATA_RST;
      endcase
    end
  end
endmodule

// ===== logic/smd_ram.sv
// Single-port synchronous memory, read data one cycle after the address
module smd_ram #(
  parameter int DW    = 16,
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  // Clock
  input  wire logic          clk,
  // Access port
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output      logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [DEPTH];

  initial begin
    if (DEPTH > (1 << AW)) $error("smd_ram: DEPTH does not fit AW");
  end

  // No reset on the array, contents are undefined until written
  always_ff @(posedge clk) begin
    if (we && (32'(addr) < DEPTH)) begin
      mem[addr] <= wdata;
    end
    rdata <= (32'(addr) < DEPTH) ? mem[addr] : '0;
  end
endmodule

// ===== shared/smd_pkg.sv
package smd_pkg;
  // Area selection codes
  localparam logic [2:0]  SEL_CODE1     = 3'h1;
  localparam logic [2:0]  SEL_CODE2     = 3'h2;
  localparam logic [2:0]  SEL_DATA      = 3'h4;
  // Address limits of the areas
  localparam logic [9:0]  CODE_LAST     = 10'h3FE;
  localparam int          CODE_DEPTH    = 1023;
  localparam logic [9:0]  DATA1_LAST    = 10'h03F;
  localparam logic [9:0]  DATA2_LAST    = 10'h07F;
  localparam logic [5:0]  PRIV_FIRST    = 6'h30;
  localparam int          DATA_DEPTH    = 64;
  localparam logic [9:0]  CFG_FIRST     = 10'h100;
  localparam logic [9:0]  CFG_LAST      = 10'h19F;
  localparam int          CFG_DEPTH     = 160;
  localparam int          CFG_BANK_LSB  = 5;
  localparam int          CFG_BANKS     = 5;
  // Chip select bit positions
  localparam int          CS_DATA       = 0;
  localparam int          CS_CODE       = 1;
  localparam int          CS_CFG        = 2;
  // Timing of the clock manager
  localparam int          CLK_MHZ       = 100;
  localparam int          TICK_NS       = 1000;
  localparam int          TICK_CYCLES   = TICK_NS * CLK_MHZ / 1000;
  // Reset values
  localparam logic [15:0] DATA_RST      = 16'h0000;
  localparam logic [9:0]  PC_RST        = 10'h000;

  typedef enum logic [2:0] {AR_NONE, AR_CODE1, AR_CODE2, AR_DATA1, AR_DATA2, AR_CFG} smd_area_t;
  typedef enum logic [1:0] {BS_IDLE, BS_WRITE, BS_READ, BS_DONE} smd_bist_t;
endpackage
